// ---- osc_ctrl.sv ----
// oscillator source control block with a classic wishbone register slave
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/1ps
module osc_ctrl
    import osc_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [3:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    input  wire logic [2:0]  boot_source_config_in,
    input  wire logic [1:0]  switch_monitor_config_in,
    input  wire logic [2:0]  boot_pll_odiv_in,
    input  wire logic [2:0]  boot_pll_mult_in,
    input  wire logic [1:0]  boot_pb_div_in,
    input  wire logic        boot_sosc_en_in,
    input  wire logic        sosc_stable_in,
    input  wire logic        sys_pll_lock_in,
    input  wire logic        usb_pll_lock_in,
    input  wire logic        clock_fail_in,
    input  wire logic        wait_exec_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    output logic             irq_out,
    output logic      [2:0]  active_source_out,
    output logic      [7:0]  frc_div_ratio_out,
    output logic      [7:0]  pll_odiv_ratio_out,
    output logic      [4:0]  pll_mult_out,
    output logic      [3:0]  periph_div_ratio_out,
    output logic             periph_bus_clock_en_out,
    output logic             sosc_enable_out,
    output logic             usb_from_rc_out,
    output logic             sleep_out,
    output logic             idle_out
);
    import osc_pkg::*;

    typedef enum logic [1:0] {OSC_IDLE, OSC_SETTLE, OSC_COMMIT} osc_state_e;

    logic [2:0]  pll_output_divider;
    logic [2:0]  fast_rc_divider;
    logic [1:0]  periph_bus_divisor;
    logic [2:0]  pll_multiplier;
    logic [2:0]  current_source_select;
    logic [2:0]  requested_source_select;
    logic        source_select_lock;
    logic        wait_enters_sleep;
    logic        clock_fail_flag;
    logic        usb_from_rc_select;
    logic        slow_osc_enable;
    logic        switch_request;
    logic [TUN_W-1:0] rc_trim_value;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic        boot_pending;
    osc_state_e  state;
    logic [15:0] settle_cnt;
    logic [2:0]  sosc_sync;
    logic [2:0]  spll_sync;
    logic [2:0]  upll_sync;
    logic [2:0]  fail_sync;
    logic        slow_osc_ready;
    logic        sys_pll_locked;
    logic        usb_pll_locked;
    logic        fail_seen;
    logic [2:0]  pb_cnt;
    logic        switch_done;

    wire access   = wb_cyc_in && wb_stb_in && !wb_ack_out;
    wire wr       = access && wb_we_in;
    wire rd       = access && !wb_we_in;
    wire wr_ctl   = wr && (wb_adr_in == OFF_CONTROL);
    wire frozen   = switch_monitor_config_in[1] && source_select_lock;
    wire periph_divisor_writable = (state == OSC_IDLE);
    wire [31:0] ctl_word = {2'h0, pll_output_divider, fast_rc_divider, 1'b0, slow_osc_ready,
                            periph_divisor_writable, periph_bus_divisor, pll_multiplier, 1'b0,
                            current_source_select, 1'b0, requested_source_select,
                            source_select_lock, usb_pll_locked, sys_pll_locked, wait_enters_sleep,
                            clock_fail_flag, usb_from_rc_select, slow_osc_enable, switch_request};

    function automatic logic [7:0] pow_ratio(input logic [2:0] code);
        pow_ratio = (code == 3'h7) ? 8'hff : 8'(8'h1 << code); // 256 shown as ff (8-bit field)
    endfunction

    // status inputs from analog domain: three flops, change counts when last two agree
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sosc_sync <= 3'h0;
            spll_sync <= 3'h0;
            upll_sync <= 3'h0;
            fail_sync <= 3'h0;
        end else begin
            sosc_sync <= {sosc_sync[1:0], sosc_stable_in};
            spll_sync <= {spll_sync[1:0], sys_pll_lock_in};
            upll_sync <= {upll_sync[1:0], usb_pll_lock_in};
            fail_sync <= {fail_sync[1:0], clock_fail_in};
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            slow_osc_ready <= 1'b0;
            sys_pll_locked <= 1'b0;
            usb_pll_locked <= 1'b0;
            fail_seen      <= 1'b0;
        end else begin
            // ready falls at once when the oscillator is switched off, even mid-transition
            if (!slow_osc_enable)
                slow_osc_ready <= 1'b0;
            else if (sosc_sync[2] == sosc_sync[1])
                slow_osc_ready <= sosc_sync[2];
            if (spll_sync[2] == spll_sync[1])
                sys_pll_locked <= spll_sync[2];
            if (upll_sync[2] == upll_sync[1])
                usb_pll_locked <= upll_sync[2];
            if (fail_sync[2] == fail_sync[1])
                fail_seen <= fail_sync[2];
        end
    end

    // control and tuning register fields; boot values are caught on the first edge after reset
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            boot_pending            <= 1'b1;
            pll_output_divider      <= 3'h0;
            fast_rc_divider         <= RST_FRC_DIV;
            periph_bus_divisor      <= RST_PB_DIV;
            pll_multiplier          <= 3'h0;
            requested_source_select <= 3'h0;
            source_select_lock      <= 1'b0;
            wait_enters_sleep       <= 1'b0;
            usb_from_rc_select      <= 1'b0;
            slow_osc_enable         <= 1'b0;
            rc_trim_value           <= '0;
        end else if (boot_pending) begin
            boot_pending            <= 1'b0;
            requested_source_select <= boot_source_config_in;
            pll_output_divider      <= boot_pll_odiv_in;
            pll_multiplier          <= boot_pll_mult_in;
            periph_bus_divisor      <= boot_pb_div_in;
            slow_osc_enable         <= boot_sosc_en_in;
        end else if (wr_ctl) begin
            if (wb_sel_in[3] && !frozen) begin
                pll_output_divider <= wb_dat_in[POS_PLL_ODIV +: 3];
                fast_rc_divider    <= wb_dat_in[POS_FRC_DIV +: 3];
            end
            if (wb_sel_in[2]) begin
                if (periph_divisor_writable)
                    periph_bus_divisor <= wb_dat_in[POS_PB_DIV +: 2];
                if (!frozen)
                    pll_multiplier <= wb_dat_in[POS_PLL_MULT +: 3];
            end
            if (wb_sel_in[1] && !frozen)
                requested_source_select <= wb_dat_in[POS_REQ_SRC +: 3];
            if (wb_sel_in[0]) begin
                source_select_lock <= source_select_lock | wb_dat_in[POS_LOCK];
                wait_enters_sleep  <= wb_dat_in[POS_SLEEP];
                usb_from_rc_select <= wb_dat_in[POS_USB_RC];
                slow_osc_enable    <= wb_dat_in[POS_SOSC_EN];
            end
        end else if (wr && wb_adr_in == OFF_TUNING && wb_sel_in[0]) begin
            rc_trim_value <= wb_dat_in[TUN_W-1:0];
        end
    end

    // switch sequencer: hold the old source until the new one has settled
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state                 <= OSC_IDLE;
            switch_request        <= 1'b0;
            settle_cnt            <= 16'h0;
            current_source_select <= 3'h0;
            switch_done           <= 1'b0;
        end else begin
            switch_done <= 1'b0;
            if (boot_pending)
                current_source_select <= boot_source_config_in;
            case (state)
                OSC_IDLE: begin
                    if (wr_ctl && wb_sel_in[0] && wb_dat_in[POS_SWITCH] && !frozen) begin
                        switch_request <= 1'b1;
                        settle_cnt     <= 16'h0;
                        state          <= OSC_SETTLE;
                    end
                end
                OSC_SETTLE: begin
                    if (settle_cnt < 16'(SETTLE - 1))
                        settle_cnt <= settle_cnt + 16'h1;
                    else if ((requested_source_select != SRC_SEC || slow_osc_ready) &&
                             (!(requested_source_select inside {SRC_FRC_PLL, SRC_PRI_PLL}) ||
                              sys_pll_locked))
                        state <= OSC_COMMIT;
                end
                OSC_COMMIT: begin
                    current_source_select <= requested_source_select;
                    switch_request        <= 1'b0;
                    switch_done           <= 1'b1;
                    state                 <= OSC_IDLE;
                end
                default: state <= OSC_IDLE;
            endcase
        end
    end

    // clock fail flag: monitor sets, software may write zero; set wins
    always_ff @(posedge clk_in) begin
        if (!rst_n_in)
            clock_fail_flag <= 1'b0;
        else if (fail_seen && !switch_monitor_config_in[1])
            clock_fail_flag <= 1'b1;
        else if (wr_ctl && wb_sel_in[0] && !wb_dat_in[POS_FAIL])
            clock_fail_flag <= 1'b0;
    end

    // interrupt status: events set, a read of the status register clears; set wins
    wire [IRQ_W-1:0] irq_events = {clock_fail_flag & ~irq_status[IRQ_CLOCK_FAIL] & fail_seen,
                                   switch_done};
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_status <= '0;
            irq_mask   <= '0;
        end else begin
            if (rd && wb_adr_in == OFF_IRQ_STATUS)
                irq_status <= irq_events;
            else
                irq_status <= irq_status | irq_events;
            if (wr && wb_adr_in == OFF_IRQ_MASK && wb_sel_in[0])
                irq_mask <= wb_dat_in[IRQ_W-1:0];
        end
    end

    // wishbone slave: one wait state, unmapped reads return zero and are acked
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wb_ack_out <= 1'b0;
            wb_dat_out <= 32'h0;
        end else begin
            wb_ack_out <= access;
            if (rd) begin
                case (wb_adr_in)
                    OFF_CONTROL:    wb_dat_out <= ctl_word;
                    OFF_TUNING:     wb_dat_out <= {26'h0, rc_trim_value};
                    OFF_IRQ_STATUS: wb_dat_out <= {30'h0, irq_status};
                    OFF_IRQ_MASK:   wb_dat_out <= {30'h0, irq_mask};
                    default:        wb_dat_out <= 32'h0;
                endcase
            end
        end
    end

    // peripheral bus clock enable divider
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pb_cnt                  <= 3'h0;
            periph_bus_clock_en_out <= 1'b0;
        end else begin
            pb_cnt                  <= (pb_cnt >= 3'(periph_div_ratio_out - 4'h1)) ? 3'h0 : pb_cnt + 3'h1;
            periph_bus_clock_en_out <= (pb_cnt == 3'h0);
        end
    end

    // registered derived outputs
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            irq_out              <= 1'b0;
            active_source_out    <= 3'h0;
            frc_div_ratio_out    <= 8'h2;
            pll_odiv_ratio_out   <= 8'h1;
            pll_mult_out         <= 5'd15;
            periph_div_ratio_out <= 4'h8;
            sosc_enable_out      <= 1'b0;
            usb_from_rc_out      <= 1'b0;
            sleep_out            <= 1'b0;
            idle_out             <= 1'b0;
        end else begin
            irq_out              <= |(irq_status & irq_mask);
            active_source_out    <= current_source_select;
            frc_div_ratio_out    <= pow_ratio(fast_rc_divider);
            pll_odiv_ratio_out   <= pow_ratio(pll_output_divider);
            pll_mult_out         <= (pll_multiplier == 3'h7) ? 5'd24 : 5'(5'd15 + pll_multiplier);
            periph_div_ratio_out <= 4'(4'h1 << periph_bus_divisor);
            sosc_enable_out      <= slow_osc_enable;
            usb_from_rc_out      <= usb_from_rc_select;
            sleep_out            <= wait_exec_in && wait_enters_sleep;
            idle_out             <= wait_exec_in && !wait_enters_sleep;
        end
    end

    AST_SWITCH_CLEARS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state == OSC_COMMIT) |=> !switch_request && current_source_select == $past(requested_source_select))
        else $error("switch did not complete");
    AST_PB_GUARD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state != OSC_IDLE && !boot_pending) |=> $stable(periph_bus_divisor))
        else $error("divisor changed while not writable");
    AST_SLEEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (wait_exec_in && wait_enters_sleep) |=> sleep_out && !idle_out)
        else $error("wait did not sleep");
    AST_FROZEN: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (frozen && !boot_pending) |=> $stable(requested_source_select) && $stable(pll_multiplier))
        else $error("locked selection changed");
    AST_SOSC_RDY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        slow_osc_ready |-> $past(slow_osc_enable))
        else $error("slow ready while disabled");
    AST_FAIL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (fail_seen && !switch_monitor_config_in[1]) |=> clock_fail_flag)
        else $error("clock fail not flagged");
    AST_MULT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (pll_multiplier == 3'h7) |=> pll_mult_out == 5'd24)
        else $error("multiplier code 7 not 24");
    AST_SETTLE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(switch_request) |-> switch_request [*2])
        else $error("switch completed without settling");
endmodule

// ---- osc_ctrl_tb.sv ----
// self-checking bench for the oscillator source control block
`timescale 1ns/1ps
module osc_ctrl_tb;
    import osc_pkg::*;
    logic        clk_in, rst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, boot_sosc_en_in;
    logic [3:0]  wb_adr_in, wb_sel_in, periph_div_ratio_out;
    logic [31:0] wb_dat_in, wb_dat_out, q;
    logic [2:0]  boot_source_config_in, boot_pll_odiv_in, boot_pll_mult_in, active_source_out;
    logic [1:0]  switch_monitor_config_in, boot_pb_div_in, pb;
    logic        sosc_stable_in, sys_pll_lock_in, usb_pll_lock_in, clock_fail_in, wait_exec_in;
    logic        wb_ack_out, irq_out, periph_bus_clock_en_out, sosc_enable_out, usb_from_rc_out;
    logic        sleep_out, idle_out, ia;
    logic [7:0]  frc_div_ratio_out, pll_odiv_ratio_out, lo;
    logic [4:0]  pll_mult_out;
    logic [2:0]  od, fr, mu, src, rq;
    int          seed = 69, n_fail = 0, checks = 0, cyc_cnt = 0, n;

    osc_ctrl #(.SETTLE(2)) dut (
        .clk_in, .rst_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
        .boot_source_config_in, .switch_monitor_config_in, .boot_pll_odiv_in, .boot_pll_mult_in,
        .boot_pb_div_in, .boot_sosc_en_in, .sosc_stable_in, .sys_pll_lock_in, .usb_pll_lock_in,
        .clock_fail_in, .wait_exec_in, .wb_dat_out, .wb_ack_out, .irq_out, .active_source_out,
        .frc_div_ratio_out, .pll_odiv_ratio_out, .pll_mult_out, .periph_div_ratio_out,
        .periph_bus_clock_en_out, .sosc_enable_out, .usb_from_rc_out, .sleep_out, .idle_out
    );

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 30000) begin
            n_fail = n_fail + 1;
            results();
        end
    end

    function automatic logic [7:0] ratio(input logic [2:0] c);
        return (c == 3'h7) ? 8'hff : 8'h01 << c;
    endfunction

    function automatic logic [4:0] mult(input logic [2:0] c);
        return (c == 3'h7) ? 5'h18 : 5'h0f + c;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
        int k;
        @(posedge clk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in  <= we;
        wb_adr_in <= a;
        wb_sel_in <= s;
        wb_dat_in <= d;
        k = 0;
        do begin
            @(posedge clk_in);
            k = k + 1;
        end while (wb_ack_out !== 1'b1);
        q = wb_dat_out;
        chk(k, 32'd2);
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        wb(1'b0, a, 4'hf, 32'h0);
    endtask

    // whole control word and the source, ratio and enable outputs against the shadow state
    task automatic cmp;
        repeat (8) @(posedge clk_in);
        rd(OFF_CONTROL);
        chk(q, {2'h0, od, fr, 1'b0, lo[1] & sosc_stable_in, ~lo[0], pb, mu, 1'b0, src, 1'b0, rq, lo[7],
                usb_pll_lock_in, sys_pll_lock_in, lo[4:0]});
        chk(active_source_out, src);
        chk(frc_div_ratio_out, ratio(fr));
        chk(pll_odiv_ratio_out, ratio(od));
        chk(pll_mult_out, mult(mu));
        chk(periph_div_ratio_out, 4'h1 << pb);
        chk({sosc_enable_out, usb_from_rc_out}, {lo[1], lo[2]});
    endtask

    task automatic poll;
        n = 0;
        do begin
            rd(OFF_CONTROL);
            n = n + 1;
        end while (q[POS_SWITCH] !== 1'b0 && n < 50);
    endtask

    task automatic reset_dut;
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        {boot_source_config_in, boot_pll_odiv_in, boot_pll_mult_in, boot_pb_div_in, boot_sosc_en_in}
            <= 12'($random(seed));
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        {src, od, mu, pb} = {boot_source_config_in, boot_pll_odiv_in, boot_pll_mult_in, boot_pb_div_in};
        rq = src;
        fr = RST_FRC_DIV;
        lo = {6'h0, boot_sosc_en_in, 1'b0};
    endtask

    initial begin
        {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_sel_in, wb_dat_in, rst_n_in} = '0;
        {boot_source_config_in, boot_pll_odiv_in, boot_pll_mult_in, boot_pb_div_in, boot_sosc_en_in} = '0;
        {switch_monitor_config_in, sosc_stable_in, sys_pll_lock_in, usb_pll_lock_in} = '0;
        {clock_fail_in, wait_exec_in} = '0;
        reset_dut();
        cmp();
        done("reset");
        for (int i = 0; i < 8; i++) begin
            od = 3'(i);
            mu = 3'(i);
            pb = 2'(i);
            fr = 3'($random(seed));
            wb(1'b1, OFF_CONTROL, 4'hc, {2'h0, od, fr, 3'h0, pb, mu, 16'h0});
            cmp();
            // spacing between peripheral clock enables
            n = 0;
            while (periph_bus_clock_en_out !== 1'b1 && n < 20) begin
                @(posedge clk_in);
                n = n + 1;
            end
            n = 0;
            do begin
                @(posedge clk_in);
                n = n + 1;
            end while (periph_bus_clock_en_out !== 1'b1 && n < 20);
            chk(n, 32'h1 << pb);
        end
        done("dividers");
        for (int j = 0; j < 4; j++) begin
            lo[4] = j[0];
            lo[2] = j[1];
            lo[1] = j[1];
            wb(1'b1, OFF_CONTROL, 4'h1, {24'h0, lo});
            {sosc_stable_in, sys_pll_lock_in, usb_pll_lock_in} <= 3'($random(seed));
            wait_exec_in <= 1'b1;
            @(posedge clk_in);
            wait_exec_in <= 1'b0;
            @(posedge clk_in);
            chk({sleep_out, idle_out}, {lo[4], ~lo[4]});
            cmp();
        end
        done("modes and status");
        // switch to the secondary source stalls until it is stable
        wb(1'b1, OFF_IRQ_MASK, 4'hf, 32'h0);
        sosc_stable_in <= 1'b0;
        sys_pll_lock_in <= 1'b1;
        // let the synchronised ready flag drop before the switch is asked for
        repeat (8) @(posedge clk_in);
        rq = SRC_SEC;
        lo[1:0] = 2'h3;
        wb(1'b1, OFF_CONTROL, 4'h3, {16'h0, 5'h0, rq, lo});
        repeat (20) @(posedge clk_in);
        wb(1'b1, OFF_CONTROL, 4'h4, {11'h0, ~pb, mu, 16'h0});
        cmp();
        sosc_stable_in <= 1'b1;
        poll();
        src = rq;
        lo[0] = 1'b0;
        cmp();
        ia = irq_out;
        wb(1'b1, OFF_IRQ_MASK, 4'hf, 32'h3);
        repeat (4) @(posedge clk_in);
        chk({ia, irq_out}, 2'b01);
        rd(OFF_IRQ_STATUS);
        chk(q, 32'h1);
        repeat (4) @(posedge clk_in);
        chk(irq_out, 1'b0);
        for (int j = 0; j < 6; j++) begin
            rq = 3'($random(seed));
            lo[0] = 1'b1;
            wb(1'b1, OFF_CONTROL, 4'h3, {16'h0, 5'h0, rq, lo});
            poll();
            src = rq;
            lo[0] = 1'b0;
            cmp();
        end
        rd(OFF_IRQ_STATUS);
        chk(q, 32'h1);
        done("switch");
        // fail flag only while monitoring is enabled
        for (int m = 0; m < 2; m++) begin
            switch_monitor_config_in <= {1'(m), 1'b0};
            clock_fail_in <= 1'b1;
            repeat (6) @(posedge clk_in);
            clock_fail_in <= 1'b0;
            lo[3] = ~1'(m);
            cmp();
            rd(OFF_IRQ_STATUS);
            chk(q, {30'h0, lo[3], 1'b0});
            lo[3] = 1'b0;
            wb(1'b1, OFF_CONTROL, 4'h1, {24'h0, lo});
            cmp();
        end
        // lock bit freezes selections only with switching disabled
        switch_monitor_config_in <= 2'h0;
        lo[7] = 1'b1;
        wb(1'b1, OFF_CONTROL, 4'h1, {24'h0, lo});
        for (int m = 0; m < 2; m++) begin
            switch_monitor_config_in <= {1'(m), 1'b0};
            wb(1'b1, OFF_CONTROL, 4'ha, {2'h0, ~od, ~fr, 8'h0, 5'h0, ~rq, 8'h0});
            if (m == 0) begin
                {od, fr, rq} = ~{od, fr, rq};
            end
            cmp();
        end
        wb(1'b1, OFF_TUNING, 4'hf, 32'hffffffff);
        rd(OFF_TUNING);
        chk(q, 32'h3f);
        done("fail, lock, tuning");
        reset_dut();
        cmp();
        done("second reset");
        results();
    end
endmodule

// ---- osc_pkg.sv ----
// oscillator source control: register map, field layout and timing constants
package osc_pkg;
    localparam int          ADDR_W           = 4;
    localparam logic [3:0]  OFF_CONTROL      = 4'h0;
    localparam logic [3:0]  OFF_TUNING       = 4'h4;
    localparam logic [3:0]  OFF_IRQ_STATUS   = 4'h8;
    localparam logic [3:0]  OFF_IRQ_MASK     = 4'hc;
    // control register field positions
    localparam int          POS_PLL_ODIV     = 27;
    localparam int          POS_FRC_DIV      = 24;
    localparam int          POS_SOSC_RDY     = 22;
    localparam int          POS_PB_WRITABLE  = 21;
    localparam int          POS_PB_DIV       = 19;
    localparam int          POS_PLL_MULT     = 16;
    localparam int          POS_CUR_SRC      = 12;
    localparam int          POS_REQ_SRC      = 8;
    localparam int          POS_LOCK         = 7;
    localparam int          POS_USB_LOCKED   = 6;
    localparam int          POS_SYS_LOCKED   = 5;
    localparam int          POS_SLEEP        = 4;
    localparam int          POS_FAIL         = 3;
    localparam int          POS_USB_RC       = 2;
    localparam int          POS_SOSC_EN      = 1;
    localparam int          POS_SWITCH       = 0;
    localparam int          TUN_W            = 6;
    // reset values
    localparam logic [2:0]  RST_FRC_DIV      = 3'h1;
    localparam logic [1:0]  RST_PB_DIV       = 2'h3;
    // source codes
    localparam logic [2:0]  SRC_FRC          = 3'h0;
    localparam logic [2:0]  SRC_FRC_PLL      = 3'h1;
    localparam logic [2:0]  SRC_PRI_PLL      = 3'h3;
    localparam logic [2:0]  SRC_SEC          = 3'h4;
    // interrupt status bits
    localparam int          IRQ_SWITCH_DONE  = 0;
    localparam int          IRQ_CLOCK_FAIL   = 1;
    localparam int          IRQ_W            = 2;
    // least settle time of a new source before switching over, in ns
    localparam int          SETTLE_NS        = 1000;
    localparam int          CLK_MHZ          = 40;
    localparam int          SETTLE_CYC       = (SETTLE_NS * CLK_MHZ + 999) / 1000;
endpackage
